// file: rtl/tag_id_filter_config.sv
`timescale 1ns/1ps
`include "tag_filter_defs.svh"

module tag_id_filter_config #(
  parameter int TICK_CYCLES = `TICK_PERIOD_S * `CLK_HZ
) (
  input logic ref_clk,
  input logic rst_n,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic tag_valid,
  input tag_filter_pkg::tag_in_s tag_in,
  output logic ser_valid,
  output tag_filter_pkg::tag_out_s ser_data,
  output logic card_valid,
  output logic [`ID_W-1:0] card_id,
  output logic lock_relay,
  output logic relay_ctl_en,
  output logic sort_enable,
  output logic tag_init,
  output logic cmd_ack
);

  localparam tag_filter_pkg::cfg_s CFG_RST = '{
    proto_en: `DEF_PROTO_EN,
    xmit_all: 1'b0,
    alt2: 1'b0,
    sort_init: 1'b1,
    sort: 1'b0,
    translate: 1'b0,
    card: 1'b0,
    tsel: tag_filter_pkg::TO_LONG,
    uniq_n: 2'h0,
    valid_n: 2'h0,
    interval: `DEF_INTERVAL
  };

  // Bit 4 flags a character that is not a hex digit.
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
      hex_nib = {1'b0, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      hex_nib = {1'b0, c[3:0] + 4'h9};
    else
      hex_nib = 5'h10;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus and command decode.

  tag_filter_pkg::cfg_s cfg_q, cfg_d;
  logic resp_q, resp_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic ack_q, ack_d;
  logic [3:0] hist_v_q, hist_v_d;
  logic wr_cmd, cmd_hit, cmd_clr;
  logic [15:0] code;
  logic [4:0] nib_hi, nib_lo;
  tag_filter_pkg::status_s status;

  assign code = avs_writedata[15:0];
  assign nib_hi = hex_nib(avs_writedata[31:24]);
  assign nib_lo = hex_nib(avs_writedata[23:16]);
  // One wait state per access; the request is taken when resp_q is set.
  assign avs_waitrequest = (avs_read || avs_write) && !resp_q;
  assign wr_cmd = avs_write && resp_q && avs_address == `REG_CMD;
  assign status = '{rsvd: 5'h00, hist_any: |hist_v_q, cmd_err: err_q,
                    cfg: cfg_q};

  always_comb
  begin
    cfg_d = cfg_q;
    err_d = err_q;
    cmd_hit = 1'b0;
    cmd_clr = 1'b0;
    resp_d = (avs_read || avs_write) && !resp_q;
    rdata_d = rdata_q;
    if (avs_read && !resp_q)
    begin
      if (avs_address == `REG_STATUS)
        rdata_d = status;
      else
        rdata_d = 32'h0000_0000;
    end
    if (wr_cmd)
    begin
      cmd_hit = 1'b1;
      if (code[15:4] == `CMD_VALID_HI && code[3:0] <= 4'h3)
        cfg_d.valid_n = code[1:0];
      else if (code[15:4] == `CMD_UNIQ_HI && code[3:0] <= 4'h3)
      begin
        cfg_d.uniq_n = code[1:0];
        cfg_d.xmit_all = 1'b0;
      end
      else if (code == `CMD_XMIT_ALL)
        cfg_d.xmit_all = 1'b1;
      else if (code == `CMD_UNIQ_RESET)
        cmd_clr = 1'b1;
      else if (code == `CMD_TO_LONG)
      begin
        cfg_d.tsel = tag_filter_pkg::TO_LONG;
        cmd_clr = 1'b1;
      end
      else if (code == `CMD_TO_SHORT)
      begin
        cfg_d.tsel = tag_filter_pkg::TO_SHORT;
        cmd_clr = 1'b1;
      end
      else if (code == `CMD_TO_MID)
      begin
        cfg_d.tsel = tag_filter_pkg::TO_MID;
        cmd_clr = 1'b1;
      end
      else if (code == `CMD_CARD_OFF || code == `CMD_CARD_ON)
        cfg_d.card = code[0];
      else if (code == `CMD_TRANS_OFF || code == `CMD_TRANS_ON)
        cfg_d.translate = code[0];
      else if (code == `CMD_SORT_ON || code == `CMD_SORT_OFF)
        cfg_d.sort = !code[0];
      else if (code == `CMD_INIT_ON || code == `CMD_INIT_OFF)
        cfg_d.sort_init = !code[0];
      else if (code == `CMD_ALT2_OFF || code == `CMD_ALT2_ON)
        cfg_d.alt2 = code[0];
      else if (code == `CMD_INTERVAL && !nib_hi[4] && !nib_lo[4]
               && {nib_hi[3:0], nib_lo[3:0]} != 8'h00)
        cfg_d.interval = {nib_hi[3:0], nib_lo[3:0]};
      else if (code[15:4] == `CMD_PROTO_HI && code[3:0] <= 4'h9)
        cfg_d.proto_en[code[3:1]] = code[0];
      else
        cmd_hit = 1'b0;
      err_d = !cmd_hit;
    end
    ack_d = cmd_hit;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cfg_q <= CFG_RST;
      resp_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      resp_q <= resp_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      ack_q <= ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-second time base and sort initialise pulses.

  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  logic init_q, init_d;

  always_comb
  begin
    tick_d = tick_cnt_q == 32'(TICK_CYCLES - 1);
    tick_cnt_d = tick_d ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    // Initialise is sent once per second while sorting with it enabled.
    init_d = tick_q && cfg_q.sort && cfg_q.sort_init;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
      init_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      init_q <= init_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Validation, uniqueness history and output formatting.

  logic [`ID_W-1:0] last_q, last_d;
  logic [2:0] rep_q, rep_d;
  logic [3:0][`ID_W-1:0] hist_q, hist_d;
  logic [7:0] to_cnt_q, to_cnt_d, retx_q, retx_d, to_limit;
  logic [`ID_W-1:0] card_last_q, card_last_d, card_id_q, card_id_d;
  logic ser_valid_q, ser_valid_d, card_valid_q, card_valid_d;
  tag_filter_pkg::tag_out_s ser_data_q, ser_data_d;
  logic lock_q, lock_d;
  logic tag_ok, grp_ok, same_last, vld_hit, same_head, dup;
  logic expire, report, card_ok, card_emit;
  logic [3:0] hv, match;

  always_comb
  begin
    case (cfg_q.tsel)
      tag_filter_pkg::TO_SHORT: to_limit = 8'(`TO_SHORT_S);
      tag_filter_pkg::TO_MID: to_limit = 8'(`TO_MID_S);
      default: to_limit = 8'(`TO_LONG_MIN * 60);
    endcase
  end

  // Bytes at tag addresses 10 and 12 through 17.
  assign grp_ok = tag_in.grp[0] == `GRP_A10 && tag_in.grp[2] == `GRP_A12
                  && tag_in.grp[3] == `GRP_A13 && tag_in.grp[4] == `GRP_A14
                  && tag_in.grp[5] == `GRP_A15 && tag_in.grp[6] == `GRP_A16
                  && tag_in.grp[7] == `GRP_A17;
  assign tag_ok = (tag_in.proto > tag_filter_pkg::EXT_TRUCK
                   || cfg_q.proto_en[tag_in.proto])
                  && (!cfg_q.alt2 || grp_ok);
  assign same_last = rep_q != 3'h0 && tag_in.id == last_q;
  always_comb
  begin
    if (!(tag_valid && tag_ok))
      rep_d = rep_q;
    else if (!same_last)
      rep_d = 3'h1;
    else if (rep_q == 3'h4)
      rep_d = rep_q;
    else
      rep_d = rep_q + 3'h1;
  end
  assign vld_hit = tag_valid && tag_ok
                   && rep_d > {1'b0, cfg_q.valid_n};
  assign expire = to_cnt_q >= to_limit;
  // Clearing happens before the store, so a tag in the same cycle is kept.
  assign hv = (expire || cmd_clr) ? 4'h0 : hist_v_q;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_match
      assign match[i] = hv[i] && hist_q[i] == tag_in.id
                        && 2'(i) <= cfg_q.uniq_n;
    end
  endgenerate

  assign dup = |match;
  assign same_head = hv[0] && hist_q[0] == tag_in.id;
  assign report = vld_hit && (cfg_q.xmit_all || !dup);
  assign card_ok = tag_in.card_fmt || cfg_q.translate;
  assign card_emit = vld_hit && cfg_q.card && card_ok
                     && (report || tag_in.id != card_last_q
                         || retx_q >= cfg_q.interval);

  always_comb
  begin
    last_d = last_q;
    hist_d = hist_q;
    hist_v_d = hv;
    to_cnt_d = to_cnt_q;
    retx_d = retx_q;
    card_last_d = card_last_q;
    card_id_d = card_id_q;
    ser_data_d = ser_data_q;
    ser_valid_d = 1'b0;
    card_valid_d = 1'b0;
    lock_d = 1'b0;
    if (tick_q)
    begin
      if (to_cnt_q != 8'hFF)
        to_cnt_d = to_cnt_q + 8'h01;
      if (retx_q != 8'hFF)
        retx_d = retx_q + 8'h01;
    end
    if (expire || cmd_clr)
      to_cnt_d = 8'h00;
    if (tag_valid && tag_ok)
      last_d = tag_in.id;
    if (vld_hit)
    begin
      lock_d = cfg_q.card;
      to_cnt_d = 8'h00;
      if (!same_head)
      begin
        hist_d = {hist_q[2:0], tag_in.id};
        hist_v_d = {hv[2:0], 1'b1};
      end
    end
    // Serial data continues in card mode, restricted to card-capable tags.
    if (report && (!cfg_q.card || card_ok))
    begin
      ser_valid_d = 1'b1;
      ser_data_d.id = tag_in.id;
      ser_data_d.translate = cfg_q.translate && !cfg_q.xmit_all
                             && tag_in.rail_fmt
                             && tag_in.frame == tag_filter_pkg::FRAME_FULL;
    end
    if (card_emit)
    begin
      card_valid_d = 1'b1;
      card_id_d = tag_in.id;
      card_last_d = tag_in.id;
      retx_d = 8'h00;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      last_q <= '0;
      rep_q <= 3'h0;
      hist_q <= '0;
      hist_v_q <= 4'h0;
      to_cnt_q <= 8'h00;
      retx_q <= 8'h00;
      card_last_q <= '0;
      card_id_q <= '0;
      ser_data_q <= '0;
      ser_valid_q <= 1'b0;
      card_valid_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      rep_q <= rep_d;
      last_q <= last_d;
      hist_q <= hist_d;
      hist_v_q <= hist_v_d;
      to_cnt_q <= to_cnt_d;
      retx_q <= retx_d;
      card_last_q <= card_last_d;
      card_id_q <= card_id_d;
      ser_data_q <= ser_data_d;
      ser_valid_q <= ser_valid_d;
      card_valid_q <= card_valid_d;
      lock_q <= lock_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign ser_valid = ser_valid_q;
  assign ser_data = ser_data_q;
  assign card_valid = card_valid_q;
  assign card_id = card_id_q;
  assign lock_relay = lock_q;
  assign relay_ctl_en = !cfg_q.card;
  assign sort_enable = cfg_q.sort;
  assign tag_init = init_q;
  assign cmd_ack = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence cmd_s(logic [15:0] c);
    wr_cmd && code == c;
  endsequence

  valid_run_a: assert property (
    ser_valid_q && $past(cfg_q.valid_n) != 2'h0
    |-> $past(same_last) && $past(rep_q) >= {1'b0, $past(cfg_q.valid_n)})
    else $error("ID reported before enough identical reads");
  report_path_a: assert property (
    ser_valid_q |-> $past(vld_hit))
    else $error("ID reported without validation");
  uniq_reset_a: assert property (
    cmd_s(`CMD_UNIQ_RESET) |=> (hist_v_q & 4'hE) == 4'h0
                               && to_cnt_q == 8'h00)
    else $error("Uniqueness reset left history or timer");
  short_limit_a: assert property (
    cfg_q.tsel == tag_filter_pkg::TO_SHORT |-> to_cnt_q <= 8'h0F)
    else $error("Short timeout overran");
  to_select_a: assert property (
    (cmd_s(`CMD_TO_LONG) or cmd_s(`CMD_TO_SHORT) or cmd_s(`CMD_TO_MID))
    |=> (hist_v_q & 4'hE) == 4'h0)
    else $error("Timeout selection did not clear history");
  expire_new_a: assert property (
    expire && !vld_hit |=> hist_v_q == 4'h0 && to_cnt_q == 8'h00)
    else $error("Expiry did not empty history");
  hold_timer_a: assert property (
    vld_hit && same_head |=> to_cnt_q == 8'h00 ##1 to_cnt_q <= 8'h01)
    else $error("Timer not held by a repeating ID");
  card_relay_a: assert property (
    cfg_q.card |-> !relay_ctl_en)
    else $error("Relay control active in card mode");
  lock_pulse_a: assert property (
    vld_hit && cfg_q.card |=> lock_relay)
    else $error("Lock relay missed in card mode");
  card_drop_a: assert property (
    card_valid_q |-> $past(card_ok) && $past(cfg_q.card))
    else $error("Non-card tag sent on card interface");
  no_trans_a: assert property (
    ser_valid_q && $past(cfg_q.xmit_all) |-> !ser_data_q.translate)
    else $error("Translation active in transmit-all mode");
  group_gate_a: assert property (
    ser_valid_q && $past(cfg_q.alt2) |-> $past(grp_ok))
    else $error("Group select mismatch reported");
  cmd_ack_a: assert property (
    cmd_hit |=> cmd_ack ##1 !cmd_ack)
    else $error("Command acknowledge missing or long");

endmodule

// file: inc/tag_filter_defs.svh
`ifndef TAG_FILTER_DEFS_SVH
`define TAG_FILTER_DEFS_SVH
// Function
// - Pass an ID only after 1 to 4 identical reads in a row; default 1.
// - Run validation before uniqueness; never report an unvalidated ID.
// - Reset-uniqueness command restarts filtering and zeroes the uniqueness timer.
// - Uniqueness timeout of 2 minutes (default), 15 s or 30 s.
// - Any timeout selection expires the clock and empties the history.
// - After expiry the first ID is new; compare only against newer entries.
// - Same ID keeps timer in reset; else unchanged ID re-reported per period.
// - Card-format mode on/off (off default); it inhibits relay control.
// - Card mode drops non-card tags unless translation is on, but pulses lock relay.
// - Card mode still takes commands and still sends serial data for card-capable tags.
// - Translation off sends raw; on translates rail/truck full frames only.
// - Transmit-all diagnostic setting suppresses translation.
// - Multi-tag sort with separate enable and disable; off by default.
// - Sort initialisation on (default) sends tag initialise during sort.
// - Sort initialisation off sends no initialise, so only new tags show.
// - Second alternate group select drops tags with mismatching bytes.
// - Card data retransmit interval 01 to FF seconds; default 1 second.
// - Interval hex digits accepted in upper or lower case.
// - Retransmit interval also covers translated non-card tags.
// - Per-protocol read enables with paired disable and enable codes.
// - Four-entry history; report if unlike first N+1 entries, N default 0.
// - Store every new validated ID in history even when not reported.
`define ID_W 64
`define CLK_HZ 100000000
`define TICK_PERIOD_S 1
`define TO_LONG_MIN 2
`define TO_SHORT_S 15
`define TO_MID_S 30
`define REG_CMD 4'h0
`define REG_STATUS 4'h4
`define CMD_XMIT_ALL 16'h0040
`define CMD_UNIQ_HI 12'h410
`define CMD_VALID_HI 12'h420
`define CMD_UNIQ_RESET 16'h0440
`define CMD_TO_LONG 16'h0441
`define CMD_TO_SHORT 16'h0442
`define CMD_TO_MID 16'h0443
`define CMD_CARD_OFF 16'h0450
`define CMD_CARD_ON 16'h0451
`define CMD_TRANS_OFF 16'h0452
`define CMD_TRANS_ON 16'h0453
`define CMD_SORT_ON 16'h0454
`define CMD_SORT_OFF 16'h0455
`define CMD_INIT_ON 16'h0456
`define CMD_INIT_OFF 16'h0457
`define CMD_ALT2_OFF 16'h0458
`define CMD_ALT2_ON 16'h0459
`define CMD_INTERVAL 16'h0046
`define CMD_PROTO_HI 12'h048
`define DEF_INTERVAL 8'h01
`define DEF_PROTO_EN 5'h1F
`define GRP_A10 8'h00
`define GRP_A12 8'h01
`define GRP_A13 8'h51
`define GRP_A14 8'h58
`define GRP_A15 8'h71
`define GRP_A16 8'h11
`define GRP_A17 8'h06
`endif

// file: inc/tag_filter_pkg.sv
`include "tag_filter_defs.svh"
package tag_filter_pkg;
  typedef enum logic [1:0] {
    TO_LONG = 2'b00,
    TO_SHORT = 2'b01,
    TO_MID = 2'b10
  } tsel_e;
  typedef enum logic [1:0] {
    FRAME_FULL = 2'b00,
    FRAME_HALF = 2'b01,
    FRAME_DUAL = 2'b10
  } frame_e;
  typedef enum logic [2:0] {
    TRUCKING = 3'b000,
    VENDOR_A = 3'b001,
    VENDOR_B = 3'b010,
    INTERAGENCY = 3'b011,
    EXT_TRUCK = 3'b100,
    OTHER = 3'b101
  } proto_e;
  typedef struct packed {
    logic [`ID_W-1:0] id;
    proto_e proto;
    frame_e frame;
    logic card_fmt;
    logic rail_fmt;
    logic [7:0][7:0] grp;
  } tag_in_s;
  typedef struct packed {
    logic [`ID_W-1:0] id;
    logic translate;
  } tag_out_s;
  typedef struct packed {
    logic [4:0] proto_en;
    logic xmit_all;
    logic alt2;
    logic sort_init;
    logic sort;
    logic translate;
    logic card;
    tsel_e tsel;
    logic [1:0] uniq_n;
    logic [1:0] valid_n;
    logic [7:0] interval;
  } cfg_s;
  typedef struct packed {
    logic [4:0] rsvd;
    logic hist_any;
    logic cmd_err;
    cfg_s cfg;
  } status_s;
endpackage

// file: tb/tag_host_model.sv
`timescale 1ns/1ps

// Host side of the command port: a plain Avalon-MM master.
module tag_host_model (
  input logic ref_clk,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic cmd_ack
);
  initial
  begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // The request is held until waitrequest is sampled low at a rising edge.
  task automatic wait_accept(output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    ok = (n < 50);
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
                           output logic ack, output logic ok);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_accept(ok);
    avs_write <= 1'b0;
    // Released data is scrambled so a stale value cannot look valid.
    avs_writedata <= ~d;
    #1;
    ack = cmd_ack;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [31:0] q,
                          output logic ok);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_accept(ok);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_address <= ~a;
  endtask
endmodule

// file: tb/tag_id_filter_config_tb.sv
`timescale 1ns/1ps
`include "tag_filter_defs.svh"

`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module tag_id_filter_config_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic tag_valid = 1'b0;
  tag_filter_pkg::tag_in_s tag_in = '0;
  tag_filter_pkg::tag_in_s tv;
  logic ser_valid, card_valid, lock_relay, relay_ctl_en;
  logic sort_enable, tag_init, cmd_ack;
  tag_filter_pkg::tag_out_s ser_data;
  logic [`ID_W-1:0] card_id;
  int failures = 0;
  int num_checks = 0;
  logic [4:0] en;
  int cnt;

  always #5 ref_clk = ~ref_clk;

  // A short second keeps every timeout inside a brief run.
  tag_id_filter_config #(.TICK_CYCLES(20)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tag_valid(tag_valid),
    .tag_in(tag_in), .ser_valid(ser_valid), .ser_data(ser_data),
    .card_valid(card_valid), .card_id(card_id), .lock_relay(lock_relay),
    .relay_ctl_en(relay_ctl_en), .sort_enable(sort_enable),
    .tag_init(tag_init), .cmd_ack(cmd_ack));

  tag_host_model host (
    .ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_ack(cmd_ack));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmd(input logic [31:0] d, input logic ea);
    logic a, ok;
    host.bus_write(`REG_CMD, d, a, ok);
    if (!ok)
    begin
      failures++;
      give_verdict();
    end
    `CHK("cmd_ack", ea, a)
  endtask

  task automatic st(input logic [3:0] ad, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] q;
    logic ok;
    host.bus_read(ad, q, ok);
    if (!ok)
    begin
      failures++;
      give_verdict();
    end
    `CHK("status", e & m, q & m)
  endtask

  function automatic tag_filter_pkg::tag_in_s mk(input logic [63:0] id,
    input logic [2:0] p, input logic [1:0] f, input logic c, input logic r);
    tag_filter_pkg::tag_in_s t;
    t.id = id;
    t.proto = tag_filter_pkg::proto_e'(p);
    t.frame = tag_filter_pkg::frame_e'(f);
    t.card_fmt = c;
    t.rail_fmt = r;
    t.grp = {`GRP_A17, `GRP_A16, `GRP_A15, `GRP_A14, `GRP_A13, `GRP_A12,
             8'h00, `GRP_A10};
    return t;
  endfunction

  // An expectation of x leaves that output unchecked, except lock_relay, which is always checked.
  task automatic send(input tag_filter_pkg::tag_in_s t, input logic es,
    input logic ec, input logic el, input logic et);
    @(posedge ref_clk);
    tag_valid <= 1'b1;
    tag_in <= t;
    @(posedge ref_clk);
    tag_valid <= 1'b0;
    tag_in <= ~t;
    #1;
    if (es !== 1'bx)
      `CHK("ser_valid", es, ser_valid)
    if (es === 1'b1)
      `CHK("ser_id", t.id, ser_data.id)
    if (ec !== 1'bx)
      `CHK("card_valid", ec, card_valid)
    `CHK("lock_relay", el, lock_relay)
    if (et !== 1'bx)
      `CHK("translate", et, ser_data.translate)
  endtask

  task automatic count_init(input int n);
    cnt = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      cnt += int'(tag_init === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    $display("watchdog expired");
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    st(`REG_STATUS, 32'h01F20001, 32'hFFFFFFFF);
    st(4'h8, 32'h0, 32'hFFFFFFFF);
    `CHK("relay_ctl_en", 1'b1, relay_ctl_en)
    `CHK("sort_enable", 1'b0, sort_enable)
    $display("test defaults done");

    cmd(32'h4203, 1'b1);
    st(`REG_STATUS, 32'h300, 32'h300);
    repeat (3) send(mk(64'hA, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    send(mk(64'hA, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    send(mk(64'hB, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    send(mk(64'hA, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    cmd(32'h4200, 1'b1);
    $display("test validation done");

    cmd(32'h4101, 1'b1);
    send(mk(64'hB, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    send(mk(64'hA, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    send(mk(64'hA, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    cmd(32'h4100, 1'b1);
    send(mk(64'hA, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    $display("test uniqueness done");

    cmd(32'h0442, 1'b1);
    st(`REG_STATUS, 32'h1000, 32'h3000);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    cmd(32'h0440, 1'b1);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    repeat (5)
    begin
      repeat (80) @(posedge ref_clk);
      send(mk(64'hC, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    end
    repeat (278) @(posedge ref_clk);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 0, 0, 0, 1'bx);
    repeat (340) @(posedge ref_clk);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    cmd(32'h0443, 1'b1);
    st(`REG_STATUS, 32'h2000, 32'h3000);
    cmd(32'h0441, 1'b1);
    st(`REG_STATUS, 32'h0000, 32'h3000);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    repeat (2460) @(posedge ref_clk);
    send(mk(64'hC, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    $display("test timeout done");

    cmd(32'h0451, 1'b1);
    `CHK("relay_ctl_en", 1'b0, relay_ctl_en)
    send(mk(64'hD, 3'd0, 2'd0, 0, 0), 0, 0, 1, 1'bx);
    send(mk(64'hE, 3'd0, 2'd0, 1, 0), 1, 1, 1, 1'bx);
    `CHK("card_id", 64'hE, card_id)
    send(mk(64'hE, 3'd0, 2'd0, 1, 0), 0, 0, 1, 1'bx);
    repeat (45) @(posedge ref_clk);
    send(mk(64'hE, 3'd0, 2'd0, 1, 0), 0, 1, 1, 1'bx);
    cmd({8'h66, 8'h46, 16'h0046}, 1'b1);
    st(`REG_STATUS, 32'hFF, 32'hFF);
    cmd({8'h61, 8'h42, 16'h0046}, 1'b1);
    st(`REG_STATUS, 32'hAB, 32'hFF);
    cmd({8'h30, 8'h30, 16'h0046}, 1'b0);
    st(`REG_STATUS, 32'h020000AB, 32'h020000FF);
    cmd({8'h30, 8'h31, 16'h0046}, 1'b1);
    cmd(32'h0453, 1'b1);
    send(mk(64'hF, 3'd0, 2'd0, 0, 1), 1, 1, 1, 1);
    cmd(32'h0450, 1'b1);
    `CHK("relay_ctl_en", 1'b1, relay_ctl_en)
    $display("test card mode done");

    send(mk(64'h10, 3'd0, 2'd1, 0, 1), 1, 0, 0, 0);
    send(mk(64'h11, 3'd0, 2'd2, 0, 1), 1, 0, 0, 0);
    send(mk(64'h12, 3'd0, 2'd0, 0, 1), 1, 0, 0, 1);
    send(mk(64'h13, 3'd0, 2'd0, 0, 0), 1, 0, 0, 0);
    cmd(32'h0040, 1'b1);
    send(mk(64'h12, 3'd0, 2'd0, 0, 1), 1, 0, 0, 0);
    cmd(32'h4100, 1'b1);
    cmd(32'h0452, 1'b1);
    send(mk(64'h14, 3'd0, 2'd0, 0, 1), 1, 0, 0, 0);
    $display("test translation done");

    cmd(32'h0454, 1'b1);
    `CHK("sort_enable", 1'b1, sort_enable)
    count_init(50);
    `CHK("tag_init", 1'b1, cnt >= 2)
    cmd(32'h0457, 1'b1);
    count_init(50);
    `CHK("tag_init", 0, cnt)
    cmd(32'h0456, 1'b1);
    cmd(32'h0455, 1'b1);
    `CHK("sort_enable", 1'b0, sort_enable)
    count_init(50);
    `CHK("tag_init", 0, cnt)
    $display("test sort done");

    cmd(32'h0459, 1'b1);
    send(mk(64'h20, 3'd0, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    tv = mk(64'h21, 3'd0, 2'd0, 0, 0);
    tv.grp[3] = 8'h50;
    send(tv, 0, 0, 0, 1'bx);
    tv = mk(64'h22, 3'd0, 2'd0, 0, 0);
    tv.grp[1] = 8'h5A;
    send(tv, 1, 0, 0, 1'bx);
    cmd(32'h0458, 1'b1);
    tv = mk(64'h23, 3'd0, 2'd0, 0, 0);
    tv.grp[7] = 8'h07;
    send(tv, 1, 0, 0, 1'bx);
    $display("test group select done");

    en = 5'h1F;
    for (int k = 0; k < 10; k++)
    begin
      cmd(32'h0480 + k, 1'b1);
      en[k / 2] = k[0];
      st(`REG_STATUS, {7'h0, en, 20'h0}, 32'h01F00000);
      send(mk(64'h100 + k, 3'(k / 2), 2'd0, 0, 0), k[0], 0, 0, 1'bx);
    end
    cmd(32'h0480, 1'b1);
    send(mk(64'h200, 3'd5, 2'd0, 0, 0), 1, 0, 0, 1'bx);
    $display("test protocols done");
    give_verdict();
  end
endmodule
